// ---- src/slice_alu_pkg.sv ----
package slice_alu_pkg;

  // Slice width and storage sizes
  localparam int          DATA_W         = 2;
  localparam int          FUNC_W         = 7;
  localparam int          RCODE_W        = 4;
  localparam int          FGROUP_W       = 3;
  localparam int          SCRATCH_COUNT  = 11;

  // Function bus field positions
  localparam int          FGROUP_LSB     = 4;
  localparam int          RCODE_LSB      = 0;

  // Function group codes
  localparam logic [2:0]  FG_ADD_ACC     = 3'h0;
  localparam logic [2:0]  FG_ADDR_LOAD   = 3'h1;
  localparam logic [2:0]  FG_DEC_STORE   = 3'h2;
  localparam logic [2:0]  FG_ADD_REG     = 3'h3;
  localparam logic [2:0]  FG_AND3        = 3'h4;
  localparam logic [2:0]  FG_AND_TEST    = 3'h5;

  // Register code decode table
  localparam logic [3:0]  RC_SCRATCH_MAX = 4'h9;
  localparam logic [3:0]  RC_TEMP_I      = 4'ha;
  localparam logic [3:0]  RC_ACC_I       = 4'hb;
  localparam logic [3:0]  RC_ACC_II      = 4'hc;
  localparam logic [3:0]  RC_TEMP_II     = 4'hd;
  localparam logic [3:0]  RC_ACC_III     = 4'he;
  localparam logic [3:0]  RC_TEMP_III    = 4'hf;

  // Scratchpad slot holding the temp register
  localparam logic [3:0]  TEMP_IDX       = 4'ha;

  // Mask constants and reset values
  localparam logic [1:0]  MASK_ZERO      = 2'h0;
  localparam logic [1:0]  ALL_ONES       = 2'h3;
  localparam logic [1:0]  ACC_RST        = 2'h0;
  localparam logic [1:0]  ADDR_RST       = 2'h0;
  localparam logic [1:0]  SCRATCH_RST    = 2'h0;

  // Register group selected by the low function bits
  typedef enum logic [1:0] {
    RG_I,
    RG_II,
    RG_III
  } rgroup_e;

endpackage : slice_alu_pkg

// ---- src/bit_slice_microfunction_alu.sv ----
`timescale 1ns/1ps
// Functional notes
// RULE1: Group 0 scratch: (acc AND mask)+reg+carry into acc and that reg.
// RULE2: Group 0, mask 11, register is acc: acc shifted left one bit.
// RULE3: Group 0 group II: (acc AND mask)+carry+memory into acc or temp.
// RULE4: Group 0 group III: shift acc or temp right, low bit out, fill high.
// RULE5: Group 1 scratch: address gets reg OR mask; reg gets reg+mask+carry.
// RULE6: Group 1, mask 11: address all ones, reg decremented unless carry set.
// RULE7: Group 1 group II: address gets memory OR mask; mask+memory+carry stored.
// RULE8: Group 1 group III: (mask OR not reg)+(reg AND mask)+carry written back.
// RULE9: Group 2: (mask AND acc)-1+carry into scratch or acc/temp.
// RULE10: Group 2 group III: (mask AND input bus)-1+carry into acc or temp.
// RULE11: Group 3 scratch: (acc AND mask)+reg+carry into reg; acc kept.
// RULE12: Group 3 group II behaves exactly as group 0 group II.
// RULE13: Group 3 group III: (mask AND input)+carry+reg written to reg.
// RULE14: Group 4 scratch: mask AND acc AND reg; carry out ORs result bits.
// RULE15: Group 4 group II: mask AND acc AND memory; carry out ORs result.
// RULE16: Group 4 group III: input AND mask AND reg; carry out ORs result.
// RULE17: Group 5 scratch: mask AND reg written back; zero test on carry.
// RULE18: Group 5 group II: mask AND memory stored; carry out ORs result.
// RULE19: Group 2 mask 00: carry minus one, clearing or setting destination.
// RULE20: AND groups with mask 00 clear destination and pass carry through.
// RULE21: Function group in upper three bits, register code in lower four.
// RULE22: Group I reaches ten scratch, temp and acc; II/III only acc, temp.
// RULE23: Commit on falling edge; missing clock pulse leaves registers unchanged.
// RULE24: All datapaths two bits wide; ripple carry chains slices. Here carry_out is registered, so the carry cannot ripple within one cycle.
// RULE25: Register code decode given as a table of named constants.
module bit_slice_microfunction_alu (
  // Clock and reset
  input  wire logic                                   clk,
  input  wire logic                                   rst,
  // Micro-function and mask from the sequencer
  input  wire logic [slice_alu_pkg::FUNC_W-1:0]       func_bus,
  input  wire logic [slice_alu_pkg::DATA_W-1:0]       mask_bus,
  input  wire logic                                   pulse_present,
  // Data inputs
  input  wire logic [slice_alu_pkg::DATA_W-1:0]       memory_in_bus,
  input  wire logic [slice_alu_pkg::DATA_W-1:0]       io_in_bus,
  // Carry and shift chain inputs
  input  wire logic                                   carry_in,
  input  wire logic                                   shift_in_left,
  // Register outputs
  output logic      [slice_alu_pkg::DATA_W-1:0]       accumulator,
  output logic      [slice_alu_pkg::DATA_W-1:0]       address_register,
  // Carry and shift chain outputs
  output logic                                        carry_out,
  output logic                                        shift_out_right
);
  import slice_alu_pkg::*;

  // Limits of this model, for whoever chains slices together:
  // carry_out and shift_out_right are registered on the falling edge,
  // so a wide word cannot ripple its carry within one micro-cycle here;
  // groups 6 and 7, and group 5 with register group III, store nothing;
  // rst exists only so that simulation starts from known contents,
  // the slice itself clears nothing at power-up.

  // Storage
  logic [DATA_W-1:0]   accumulator_r;
  logic [DATA_W-1:0]   address_register_r;
  logic [DATA_W-1:0]   scratch_r [0:SCRATCH_COUNT-1];
  logic                carry_out_r;
  logic                shift_out_right_r;

  // Decode results
  logic [FGROUP_W-1:0] fgroup;
  logic [RCODE_W-1:0]  rcode;
  rgroup_e             rgroup;
  logic                tgt_acc;
  logic [RCODE_W-1:0]  tgt_idx;
  logic [DATA_W-1:0]   tgt_val;

  // Operation results
  logic [DATA_W-1:0]   res;
  logic [DATA_W:0]     sum3;
  logic                cout;
  logic                sro;
  logic                wr_tgt;
  logic                wr_acc_also;
  logic                wr_addr;
  logic [DATA_W-1:0]   addr_val;

  // Commit strobes; a missing pulse blocks every scratch, accumulator and address write
  logic                commit_tgt;
  logic                commit_acc;
  logic                commit_addr;

  // Split the function bus into group and register code
  // Both fields decode in the same cycle, with no pipeline stage
  assign fgroup = func_bus[FGROUP_LSB +: FGROUP_W]; // RULE21
  assign rcode  = func_bus[RCODE_LSB +: RCODE_W]; // RULE21

  // Register code table: which group and which storage element
  always_comb begin
    rgroup  = RG_I;
    tgt_acc = 1'b0;
    tgt_idx = rcode;
    // Codes 0xa to 0xf are fixed; 0 to 9 fall through to scratch
    case (rcode)
      RC_TEMP_I: begin
        rgroup  = RG_I; // RULE25
        tgt_idx = TEMP_IDX;
      end
      RC_ACC_I: begin
        rgroup  = RG_I; // RULE25
        tgt_acc = 1'b1;
      end
      RC_ACC_II: begin
        rgroup  = RG_II; // RULE22
        tgt_acc = 1'b1;
      end
      RC_TEMP_II: begin
        rgroup  = RG_II; // RULE22
        tgt_idx = TEMP_IDX;
      end
      RC_ACC_III: begin
        rgroup  = RG_III; // RULE22
        tgt_acc = 1'b1;
      end
      RC_TEMP_III: begin
        rgroup  = RG_III; // RULE22
        tgt_idx = TEMP_IDX;
      end
      default: begin
        // Codes up to RC_SCRATCH_MAX pick scratch 0..9
        rgroup  = RG_I; // RULE22
        tgt_idx = rcode;
      end
    endcase
  end

  // Current value of the selected register, acc or scratchpad slot
  // Temp sits in slot 10, so one read mux serves scratch and temp
  always_comb begin
    tgt_val = accumulator_r;
    if (!tgt_acc && tgt_idx <= TEMP_IDX) begin
      tgt_val = scratch_r[tgt_idx];
    end
  end

  // Arithmetic/logic section; every path is one 2-bit slice wide
  always_comb begin
    res         = MASK_ZERO;
    sum3        = '0;
    cout        = carry_in;
    sro         = 1'b0;
    wr_tgt      = 1'b0;
    wr_acc_also = 1'b0;
    wr_addr     = 1'b0;
    addr_val    = ADDR_RST;
    case (fgroup)
      FG_ADD_ACC: begin
        case (rgroup)
          RG_I: begin
            // Acc as the register with mask 11 gives 2*acc+carry, a left shift
            sum3        = {1'b0, accumulator_r & mask_bus} + {1'b0, tgt_val}
                        + {{DATA_W{1'b0}}, carry_in}; // RULE1 RULE2
            res         = sum3[DATA_W-1:0];
            cout        = sum3[DATA_W]; // RULE24
            wr_tgt      = 1'b1; // RULE1
            wr_acc_also = 1'b1; // RULE1
          end
          RG_II: begin
            // Memory operand takes the register's place
            sum3   = {1'b0, accumulator_r & mask_bus} + {1'b0, memory_in_bus}
                   + {{DATA_W{1'b0}}, carry_in}; // RULE3
            res    = sum3[DATA_W-1:0];
            cout   = sum3[DATA_W];
            wr_tgt = 1'b1; // RULE3
          end
          default: begin
            // Right shift; carry passes so the chain stays defined
            res    = {shift_in_left, tgt_val[DATA_W-1:1]}; // RULE4
            sro    = tgt_val[0]; // RULE4
            wr_tgt = 1'b1; // RULE4
          end
        endcase
      end
      FG_ADDR_LOAD: begin
        case (rgroup)
          RG_I: begin
            // Mask 11 adds three: a decrement that carry can cancel
            addr_val = tgt_val | mask_bus; // RULE5 RULE6
            wr_addr  = 1'b1; // RULE5
            sum3     = {1'b0, mask_bus} + {1'b0, tgt_val}
                     + {{DATA_W{1'b0}}, carry_in}; // RULE5 RULE6
            res      = sum3[DATA_W-1:0];
            cout     = sum3[DATA_W];
            wr_tgt   = 1'b1; // RULE5
          end
          RG_II: begin
            // Mask 11 gives an all-ones address and memory minus one
            addr_val = memory_in_bus | mask_bus; // RULE7
            wr_addr  = 1'b1; // RULE7
            sum3     = {1'b0, mask_bus} + {1'b0, memory_in_bus}
                     + {{DATA_W{1'b0}}, carry_in}; // RULE7
            res      = sum3[DATA_W-1:0];
            cout     = sum3[DATA_W];
            wr_tgt   = 1'b1; // RULE7
          end
          default: begin
            // Mask 00 complements, mask 11 decrements acc or temp
            sum3   = {1'b0, mask_bus | ~tgt_val} + {1'b0, tgt_val & mask_bus}
                   + {{DATA_W{1'b0}}, carry_in}; // RULE8
            res    = sum3[DATA_W-1:0];
            cout   = sum3[DATA_W];
            wr_tgt = 1'b1; // RULE8
          end
        endcase
      end
      FG_DEC_STORE: begin
        // Minus one is added as all ones; mask 00 leaves carry-1
        if (rgroup == RG_III) begin
          sum3 = {1'b0, mask_bus & io_in_bus} + {1'b0, ALL_ONES}
               + {{DATA_W{1'b0}}, carry_in}; // RULE10 RULE19
        end else begin
          sum3 = {1'b0, mask_bus & accumulator_r} + {1'b0, ALL_ONES}
               + {{DATA_W{1'b0}}, carry_in}; // RULE9 RULE19
        end
        res    = sum3[DATA_W-1:0];
        cout   = sum3[DATA_W];
        wr_tgt = 1'b1; // RULE9 RULE10
      end
      FG_ADD_REG: begin
        case (rgroup)
          RG_I: begin
            // Only the register is written; acc untouched unless RC_ACC_I makes it the register
            sum3   = {1'b0, accumulator_r & mask_bus} + {1'b0, tgt_val}
                   + {{DATA_W{1'b0}}, carry_in}; // RULE11
            res    = sum3[DATA_W-1:0];
            cout   = sum3[DATA_W];
            wr_tgt = 1'b1; // RULE11
          end
          RG_II: begin
            // Same datapath as group 0, register group II
            sum3   = {1'b0, accumulator_r & mask_bus} + {1'b0, memory_in_bus}
                   + {{DATA_W{1'b0}}, carry_in}; // RULE12
            res    = sum3[DATA_W-1:0];
            cout   = sum3[DATA_W];
            wr_tgt = 1'b1; // RULE12
          end
          default: begin
            // Masked input bus added into acc or temp
            sum3   = {1'b0, mask_bus & io_in_bus} + {1'b0, tgt_val}
                   + {{DATA_W{1'b0}}, carry_in}; // RULE13
            res    = sum3[DATA_W-1:0];
            cout   = sum3[DATA_W];
            wr_tgt = 1'b1; // RULE13
          end
        endcase
      end
      FG_AND3: begin
        // Carry circuit reused as a word-wise OR for bit testing
        case (rgroup)
          RG_I:    res = mask_bus & accumulator_r & tgt_val; // RULE14 RULE20
          RG_II:   res = mask_bus & accumulator_r & memory_in_bus; // RULE15 RULE20
          default: res = io_in_bus & mask_bus & tgt_val; // RULE16 RULE20
        endcase
        cout   = carry_in | (|res); // RULE14 RULE15 RULE16
        wr_tgt = 1'b1;
      end
      FG_AND_TEST: begin
        // Mask 11 makes these zero tests: carry shows any one bit
        case (rgroup)
          RG_I: begin
            res    = mask_bus & tgt_val; // RULE17 RULE20
            cout   = carry_in | (|res); // RULE17
            wr_tgt = 1'b1;
          end
          RG_II: begin
            res    = mask_bus & memory_in_bus; // RULE18 RULE20
            cout   = carry_in | (|res); // RULE18
            wr_tgt = 1'b1;
          end
          default: begin
            // Not implemented here: no write, carry passes through
            res = MASK_ZERO;
          end
        endcase
      end
      default: begin
        // Unimplemented groups act as a null operation
        res = MASK_ZERO;
      end
    endcase
  end

  // A gated clock pulse is modelled by pulse_present
  assign commit_tgt = pulse_present && wr_tgt; // RULE23
  assign commit_acc = pulse_present && ((wr_tgt && tgt_acc) || wr_acc_also); // RULE23
  assign commit_addr = pulse_present && wr_addr; // RULE23

  // Scratchpad and temp register, one write port per slot
  // Slot index is a constant per copy, so each slot has one driver
  for (genvar g = 0; g < SCRATCH_COUNT; g++) begin : g_scratch
    always_ff @(negedge clk) begin
      if (rst) begin
        scratch_r[g] <= SCRATCH_RST;
      end else if (commit_tgt && !tgt_acc && tgt_idx == RCODE_W'(g)) begin
        scratch_r[g] <= res; // RULE23
      end
    end
  end

  // Accumulator, written on the falling edge only
  // Group 0 register group I writes here as well as the scratch slot
  always_ff @(negedge clk) begin
    if (rst) begin
      accumulator_r <= ACC_RST;
    end else if (commit_acc) begin
      accumulator_r <= res; // RULE1 RULE23
    end
  end

  // Address register for groups that load it
  // Other groups leave the last address standing on the pins
  always_ff @(negedge clk) begin
    if (rst) begin
      address_register_r <= ADDR_RST;
    end else if (commit_addr) begin
      address_register_r <= addr_val; // RULE5 RULE23
    end
  end

  // Chain outputs sampled every falling edge so tests work without a pulse
  // Trade-off: registered for clean outputs, at the cost of live ripple
  always_ff @(negedge clk) begin
    if (rst) begin
      carry_out_r       <= 1'b0;
      shift_out_right_r <= 1'b0;
    end else begin
      carry_out_r       <= cout; // RULE24
      shift_out_right_r <= sro; // RULE4
    end
  end

  // Every output comes straight from a flip-flop
  assign accumulator      = accumulator_r;
  assign address_register = address_register_r;
  assign carry_out        = carry_out_r;
  assign shift_out_right  = shift_out_right_r;

endmodule : bit_slice_microfunction_alu

// ---- verif/alu_props.sv ----
`timescale 1ns/1ps
module alu_props (
  // Clock and reset
  input wire logic                               clk,
  input wire logic                               rst,
  // Sequencer and data inputs
  input wire logic [slice_alu_pkg::FUNC_W-1:0]   func_bus,
  input wire logic [slice_alu_pkg::DATA_W-1:0]   mask_bus,
  input wire logic                               pulse_present,
  input wire logic [slice_alu_pkg::DATA_W-1:0]   memory_in_bus,
  input wire logic [slice_alu_pkg::DATA_W-1:0]   io_in_bus,
  input wire logic                               carry_in,
  input wire logic                               shift_in_left,
  // Slice outputs
  input wire logic [slice_alu_pkg::DATA_W-1:0]   accumulator,
  input wire logic [slice_alu_pkg::DATA_W-1:0]   address_register,
  input wire logic                               carry_out,
  input wire logic                               shift_out_right
);
  import slice_alu_pkg::*;

  // Results land on the falling edge, so every check lives there
  default clocking cb @(negedge clk);
  endclocking
  default disable iff (rst);

  // A clocked micro-function, optionally with a fixed mask
  sequence s_op(logic [6:0] f);
    pulse_present && func_bus == f;
  endsequence
  sequence s_opk(logic [6:0] f, logic [1:0] k);
    s_op(f) ##0 mask_bus == k;
  endsequence

  // Arithmetic paths on the accumulator
  a_shift_left: assert property (s_opk(7'h0b, 2'h3) |=>
    accumulator == 2'($past(accumulator) * 2 + $past(carry_in))) else $error("left shift");
  a_mem_add: assert property (s_op(7'h0c) |=> accumulator ==
    2'(($past(accumulator) & $past(mask_bus)) + $past(memory_in_bus) + $past(carry_in)))
    else $error("memory add");
  a_dec_io: assert property (s_op(7'h2e) |=> accumulator ==
    2'(($past(mask_bus) & $past(io_in_bus)) - 1 + $past(carry_in))) else $error("input dec");
  a_shift_right: assert property (s_op(7'h0e) |=>
    accumulator == {$past(shift_in_left), $past(accumulator[1])} &&
    shift_out_right == $past(accumulator[0])) else $error("right shift");

  // Address register loads
  a_addr_mem: assert property (s_op(7'h1c) |=>
    address_register == ($past(memory_in_bus) | $past(mask_bus))) else $error("addr load");
  a_addr_ones: assert property (pulse_present && func_bus[6:4] == 3'h1 &&
    func_bus[3:0] <= 4'hb && mask_bus == 2'h3 |=> address_register == 2'h3)
    else $error("addr ones");

  // Logical paths and their carry test
  a_and_mem: assert property (s_op(7'h4c) |=>
    accumulator == ($past(mask_bus) & $past(accumulator) & $past(memory_in_bus)) &&
    carry_out == ($past(carry_in) | (|accumulator))) else $error("and test");
  a_zero_test: assert property (s_op(7'h5c) |=>
    carry_out == ($past(carry_in) | (|($past(mask_bus) & $past(memory_in_bus)))))
    else $error("zero test");

  // Omitted clock pulse keeps the registers
  a_hold_no_pulse: assert property (!pulse_present |=>
    $stable(accumulator) && $stable(address_register)) else $error("no pulse");
endmodule : alu_props

bind bit_slice_microfunction_alu alu_props i_props (
  .clk(clk), .rst(rst), .func_bus(func_bus), .mask_bus(mask_bus),
  .pulse_present(pulse_present), .memory_in_bus(memory_in_bus), .io_in_bus(io_in_bus),
  .carry_in(carry_in), .shift_in_left(shift_in_left), .accumulator(accumulator),
  .address_register(address_register), .carry_out(carry_out),
  .shift_out_right(shift_out_right));

// ---- verif/micro_seq.sv ----
`timescale 1ns/1ps
module micro_seq (
  // Clock
  input  wire logic       clk,
  // Function and mask toward the slice
  output logic      [6:0] func_bus,
  output logic      [1:0] mask_bus,
  output logic            pulse_present,
  // Data, carry and shift levels
  output logic      [1:0] memory_in_bus,
  output logic      [1:0] io_in_bus,
  output logic            carry_in,
  output logic            shift_in_left
);
  // Start with the clock pulse gated off so nothing is written
  initial begin
    func_bus = 7'h00;
    mask_bus = 2'h0;
    pulse_present = 1'b0;
    memory_in_bus = 2'h0;
    io_in_bus = 2'h0;
    carry_in = 1'b0;
    shift_in_left = 1'b0;
  end

  // New code only after the rising edge; the slice commits on the falling one
  task automatic put(input logic [6:0] f, input logic [1:0] k, input logic ci,
                     input logic [1:0] m, input logic [1:0] io, input logic li,
                     input logic p);
    @(posedge clk);
    func_bus <= f;
    mask_bus <= k;
    carry_in <= ci;
    memory_in_bus <= m;
    io_in_bus <= io;
    shift_in_left <= li;
    pulse_present <= p;
    @(negedge clk);
    #1;
  endtask : put
endmodule : micro_seq

// ---- verif/bit_slice_microfunction_alu_bench.sv ----
`timescale 1ns/1ps
module bit_slice_microfunction_alu_bench;
  logic       clk;
  logic       rst;
  logic [6:0] func_bus;
  logic [1:0] mask_bus, memory_in_bus, io_in_bus, accumulator, address_register;
  logic       pulse_present, carry_in, shift_in_left, carry_out, shift_out_right;
  int         n_mismatch = 0;
  int         comparisons = 0;
  int         cycles = 0;

  // Sequencer model and the slice
  micro_seq i_seq (.clk(clk), .func_bus(func_bus), .mask_bus(mask_bus),
    .pulse_present(pulse_present), .memory_in_bus(memory_in_bus), .io_in_bus(io_in_bus),
    .carry_in(carry_in), .shift_in_left(shift_in_left));
  bit_slice_microfunction_alu i_dut (.clk(clk), .rst(rst), .func_bus(func_bus),
    .mask_bus(mask_bus), .pulse_present(pulse_present), .memory_in_bus(memory_in_bus),
    .io_in_bus(io_in_bus), .carry_in(carry_in), .shift_in_left(shift_in_left),
    .accumulator(accumulator), .address_register(address_register),
    .carry_out(carry_out), .shift_out_right(shift_out_right));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  // Hang guard; the whole run needs well under a hundred cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic check(input string what, input logic [1:0] seen, input logic [1:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One clocked op, then the accumulator judged
  task automatic run(input logic [6:0] f, input logic [1:0] k, input logic ci,
                     input logic [1:0] m, input logic [1:0] io, input logic [1:0] exp);
    i_seq.put(f, k, ci, m, io, 1'b0, 1'b1);
    check("accumulator", accumulator, exp);
  endtask : run

  task automatic t_reset();
    check("accumulator", accumulator, 2'h0);
    check("address_register", address_register, 2'h0);
    check("carry_out", {1'b0, carry_out}, 2'h0);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_shift();
    run(7'h0c, 2'h0, 1'b0, 2'h2, 2'h0, 2'h2);
    run(7'h0b, 2'h3, 1'b1, 2'h0, 2'h0, 2'h1);
    check("carry_out", {1'b0, carry_out}, 2'h1);
    i_seq.put(7'h0e, 2'h0, 1'b0, 2'h0, 2'h0, 1'b1, 1'b1);
    check("accumulator", accumulator, 2'h2);
    check("shift_out_right", {1'b0, shift_out_right}, 2'h1);
    run(7'h3c, 2'h3, 1'b1, 2'h1, 2'h0, 2'h0);
    $display("t_shift done");
  endtask : t_shift

  // Highest scratch code, read back through the accumulator
  task automatic t_scratch();
    run(7'h0c, 2'h0, 1'b1, 2'h0, 2'h0, 2'h1);
    i_seq.put(7'h49, 2'h0, 1'b1, 2'h0, 2'h0, 1'b0, 1'b1);
    check("carry_out", {1'b0, carry_out}, 2'h1);
    run(7'h39, 2'h3, 1'b0, 2'h0, 2'h0, 2'h1);
    i_seq.put(7'h19, 2'h0, 1'b1, 2'h0, 2'h0, 1'b0, 1'b1);
    check("address_register", address_register, 2'h1);
    i_seq.put(7'h19, 2'h3, 1'b0, 2'h0, 2'h0, 1'b0, 1'b1);
    check("address_register", address_register, 2'h3);
    run(7'h09, 2'h3, 1'b0, 2'h0, 2'h0, 2'h2);
    run(7'h09, 2'h0, 1'b0, 2'h0, 2'h0, 2'h2);
    i_seq.put(7'h29, 2'h0, 1'b0, 2'h0, 2'h0, 1'b0, 1'b1);
    run(7'h09, 2'h0, 1'b0, 2'h0, 2'h0, 2'h3);
    i_seq.put(7'h29, 2'h3, 1'b0, 2'h0, 2'h0, 1'b0, 1'b1);
    run(7'h09, 2'h0, 1'b0, 2'h0, 2'h0, 2'h2);
    run(7'h00, 2'h0, 1'b0, 2'h0, 2'h0, 2'h0);
    $display("t_scratch done");
  endtask : t_scratch

  task automatic t_io();
    run(7'h2e, 2'h3, 1'b1, 2'h0, 2'h2, 2'h2);
    run(7'h3e, 2'h3, 1'b1, 2'h0, 2'h3, 2'h2);
    check("carry_out", {1'b0, carry_out}, 2'h1);
    run(7'h1e, 2'h3, 1'b0, 2'h0, 2'h0, 2'h1);
    run(7'h4e, 2'h3, 1'b0, 2'h0, 2'h1, 2'h1);
    run(7'h1c, 2'h0, 1'b0, 2'h2, 2'h0, 2'h2);
    check("address_register", address_register, 2'h2);
    run(7'h2d, 2'h3, 1'b0, 2'h0, 2'h0, 2'h2);
    run(7'h0a, 2'h0, 1'b0, 2'h0, 2'h0, 2'h1);
    $display("t_io done");
  endtask : t_io

  task automatic t_and();
    run(7'h4c, 2'h3, 1'b0, 2'h3, 2'h0, 2'h1);
    i_seq.put(7'h49, 2'h3, 1'b0, 2'h0, 2'h0, 1'b0, 1'b1);
    check("carry_out", {1'b0, carry_out}, 2'h0);
    run(7'h09, 2'h0, 1'b0, 2'h0, 2'h0, 2'h0);
    run(7'h0c, 2'h0, 1'b0, 2'h3, 2'h0, 2'h3);
    i_seq.put(7'h29, 2'h0, 1'b0, 2'h0, 2'h0, 1'b0, 1'b1);
    i_seq.put(7'h59, 2'h2, 1'b0, 2'h0, 2'h0, 1'b0, 1'b1);
    check("carry_out", {1'b0, carry_out}, 2'h1);
    run(7'h09, 2'h0, 1'b0, 2'h0, 2'h0, 2'h2);
    run(7'h5c, 2'h2, 1'b0, 2'h3, 2'h0, 2'h2);
    run(7'h4c, 2'h0, 1'b0, 2'h3, 2'h0, 2'h0);
    check("carry_out", {1'b0, carry_out}, 2'h0);
    $display("t_and done");
  endtask : t_and

  // Gated pulse: an op that would change both registers
  task automatic t_no_pulse();
    i_seq.put(7'h1c, 2'h3, 1'b1, 2'h3, 2'h0, 1'b0, 1'b0);
    check("accumulator", accumulator, 2'h0);
    check("address_register", address_register, 2'h2);
    run(7'h1c, 2'h3, 1'b1, 2'h3, 2'h0, 2'h3);
    check("address_register", address_register, 2'h3);
    check("carry_out", {1'b0, carry_out}, 2'h1);
    $display("t_no_pulse done");
  endtask : t_no_pulse

  initial begin
    rst = 1'b1;
    repeat (8) @(posedge clk);
    t_reset();
    rst <= 1'b0;
    t_shift();
    t_scratch();
    t_io();
    t_and();
    t_no_pulse();
    finish_test();
  end
endmodule : bit_slice_microfunction_alu_bench
